// file: core/caption_capture.sv
// caption line data capture: input select, timing, recovery, registers
//
// The address map and the address-and-strobe port were decided locally.
`default_nettype none
// Function
// - one of two video inputs is routed to capture, chosen by software.
// - the selected input is sampled at 12 MHz and fed to recovery.
// - recovery handles only caption data near 503.5 kHz, clock and bits.
// - recovered serial bits are shifted into two bytes per line.
// - horizontal and vertical timing come from the extracted sync.
// - 625 or 525 line operation is detected automatically and only reported, not applied.
// - a quality flag is set while timing is locked, clear otherwise.
// - the line standard flag is reported, meaningful only with quality.
// - caption data is captured only while capture enable is set.
// - the captured line is set by the line select register, line 21 after reset.
// - first byte goes to the first data register, second to the second.
// - both data registers clear to 00 at start of the selected line while capture is enabled.
// - an interrupt is raised at line end only when enabled.
module caption_capture
   import caption_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   // digitised video inputs with extracted sync
   input  wire logic [7:0] video0_i,
   input  wire logic [7:0] video1_i,
   input  wire logic       hsync0_i,
   input  wire logic       vsync0_i,
   input  wire logic       hsync1_i,
   input  wire logic       vsync1_i,
   // interrupt
   output logic            irq_o
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HUNT,
      ST_DATA,
      ST_DONE
   } rx_state_e;

   typedef struct packed {
      logic        input_sel;
      logic        capture_en;
      logic [4:0]  line_sel;
      logic        irq_status;
      logic        irq_mask;
      logic [7:0]  rdata;
      logic [5:0]  smp_acc;
      logic        hs_prev;
      logic        vs_prev;
      logic [9:0]  line_cnt;
      logic [9:0]  last_lines;
      logic [2:0]  lock_cnt;
      logic        quality;
      logic        std_525;
      rx_state_e   st;
      logic [4:0]  phase;
      logic [4:0]  bit_cnt;
      logic [7:0]  prev_smp;
   } cap_state_s;

   cap_state_s s_q, s_d;
   sync_s      sync;
   logic [7:0] sample;
   logic       sample_en;
   logic       line_start;
   logic       field_start;
   logic       on_line;
   logic       line_end;
   logic       sliced;
   logic       bit_valid;
   logic       commit;
   logic       clear_bytes;
   logic [7:0] byte_first;
   logic [7:0] byte_second;

   // input switch
   always_comb begin
      if (s_q.input_sel) begin
         sample     = video1_i;
         sync.hsync = hsync1_i;
         sync.vsync = vsync1_i;
      end else begin
         sample     = video0_i;
         sync.hsync = hsync0_i;
         sync.vsync = vsync0_i;
      end
   end

   // 12 MHz enable from 50 MHz by fractional accumulator (6/25)
   assign sample_en = (s_q.smp_acc >= 6'd19);
   assign line_start  = sync.hsync & ~s_q.hs_prev;
   assign field_start = sync.vsync & ~s_q.vs_prev;
   assign on_line = (s_q.line_cnt == {5'h00, s_q.line_sel});
   assign line_end = on_line && line_start == 1'b0 && s_q.st == ST_DONE;
   assign sliced = sample >= SLICE_LEVEL;
   assign bit_valid = s_q.st == ST_DATA && sample_en
                      && s_q.phase == 5'(SAMPLES_PER_BIT / 2)
                      && s_q.bit_cnt >= 5'(START_BITS);
   assign commit = s_q.st == ST_DATA && s_q.bit_cnt
                   == 5'(START_BITS + DATA_BITS);

   assign clear_bytes = line_start && s_q.capture_en
                        && s_q.line_cnt + 10'd1 == {5'h00, s_q.line_sel};

   caption_shift u_shift (
      .clk_i         (clk_i),
      .reset_i       (reset_i),
      .clear_i       (clear_bytes),
      .bit_valid_i   (bit_valid),
      .bit_i         (sliced),
      .commit_i      (commit),
      .byte_first_o  (byte_first),
      .byte_second_o (byte_second)
   );

   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      s_d.smp_acc = sample_en ? s_q.smp_acc - 6'd19 : s_q.smp_acc + 6'd6;
      s_d.hs_prev = sync.hsync;
      s_d.vs_prev = sync.vsync;
      // line and field timing
      if (field_start) begin
         s_d.line_cnt   = 10'd0;
         s_d.last_lines = s_q.line_cnt;
         s_d.std_525 = s_q.line_cnt < 10'(LINES_THRESHOLD);
         if (s_q.line_cnt == s_q.last_lines) begin
            if (s_q.lock_cnt != 3'(LOCK_FIELDS)) begin
               s_d.lock_cnt = s_q.lock_cnt + 3'd1;
            end
         end else begin
            s_d.lock_cnt = 3'd0;
         end
      end else if (line_start) begin
         s_d.line_cnt = s_q.line_cnt + 10'd1;
      end
      s_d.quality = s_q.lock_cnt == 3'(LOCK_FIELDS);
      // recovery
      case (s_q.st)
         ST_IDLE: begin
            if (line_start && s_q.capture_en && s_q.line_cnt + 10'd1
                == {5'h00, s_q.line_sel}) begin
               s_d.st = ST_HUNT;
            end
         end
         ST_HUNT: begin
            if (sample_en) begin
               s_d.prev_smp = sample;
               if (sliced && s_q.prev_smp < SLICE_LEVEL) begin
                  s_d.st      = ST_DATA;
                  s_d.phase   = 5'd1;
                  s_d.bit_cnt = 5'd0;
               end
            end
            if (line_start) begin
               s_d.st = ST_DONE;
            end
         end
         ST_DATA: begin
            if (commit) begin
               s_d.st = ST_DONE;
            end else if (sample_en) begin
               s_d.prev_smp = sample;
               if (s_q.phase == 5'(SAMPLES_PER_BIT - 1)) begin
                  s_d.phase   = 5'd0;
                  s_d.bit_cnt = s_q.bit_cnt + 5'd1;
               end else if (sliced != (s_q.prev_smp >= SLICE_LEVEL)) begin
                  s_d.phase = 5'd1;
                  if (s_q.phase > 5'(SAMPLES_PER_BIT / 2)) begin
                     s_d.bit_cnt = s_q.bit_cnt + 5'd1;
                  end
               end else begin
                  s_d.phase = s_q.phase + 5'd1;
               end
            end
            if (line_start) begin
               s_d.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_d.st = ST_IDLE;
            s_d.irq_status = 1'b1;
         end
         default: s_d.st = ST_IDLE;
      endcase
      // register writes
      if (wr_i) begin
         if (addr_i[3:0] == OFS_INPUT_CTRL) begin
            s_d.input_sel = wdata_i[BIT_INPUT_SEL];
         end else if (addr_i[3:0] == OFS_MODE_CTRL) begin
            s_d.capture_en = wdata_i[BIT_CAPTURE_EN];
         end else if (addr_i[3:0] == OFS_LINE_SELECT) begin
            s_d.line_sel = wdata_i[4:0];
         end else if (addr_i[3:0] == OFS_IRQ_STATUS) begin
            if (wdata_i[BIT_IRQ_CAPTION] && s_q.st != ST_DONE) begin
               s_d.irq_status = 1'b0;
            end
         end else if (addr_i[3:0] == OFS_IRQ_MASK) begin
            s_d.irq_mask = wdata_i[BIT_IRQ_CAPTION];
         end
         // data registers ignore writes
      end
      if (rd_i) begin
         if (addr_i[3:0] == OFS_INPUT_CTRL) begin
            s_d.rdata = {7'h00, s_q.input_sel};
         end else if (addr_i[3:0] == OFS_MODE_CTRL) begin
            s_d.rdata = {7'h00, s_q.capture_en};
         end else if (addr_i[3:0] == OFS_LINE_SELECT) begin
            s_d.rdata = {3'h0, s_q.line_sel};
         end else if (addr_i[3:0] == OFS_STATUS) begin
            s_d.rdata = {6'h00, s_q.std_525, s_q.quality};
         end else if (addr_i[3:0] == OFS_BYTE_FIRST) begin
            s_d.rdata = byte_first;
         end else if (addr_i[3:0] == OFS_BYTE_SECOND) begin
            s_d.rdata = byte_second;
         end else if (addr_i[3:0] == OFS_IRQ_STATUS) begin
            s_d.rdata = {7'h00, s_q.irq_status};
         end else if (addr_i[3:0] == OFS_IRQ_MASK) begin
            s_d.rdata = {7'h00, s_q.irq_mask};
         end else begin
            s_d.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q          <= '0;
         s_q.line_sel <= LINE_SELECT_RST;
         s_q.st       <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign irq_o   = s_q.irq_status & s_q.irq_mask;

   // assertions
   a_irq_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      irq_o |-> s_q.irq_mask)
      else $error("irq high while masked");
   a_done_irq: assert property (@(posedge clk_i) disable iff (reset_i)
      s_q.st == ST_DONE |=> s_q.irq_status)
      else $error("line end did not set status");
   a_no_cap_off: assert property (@(posedge clk_i) disable iff (reset_i)
      s_q.st == ST_IDLE && !s_q.capture_en |=> s_q.st == ST_IDLE)
      else $error("capture started while disabled");
   a_ro_bytes: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_i && !commit && !clear_bytes
      |=> $stable(byte_first) && $stable(byte_second))
      else $error("data register changed by write");
   a_quality_lock: assert property (@(posedge clk_i) disable iff (reset_i)
      s_q.quality |-> $past(s_q.lock_cnt) == 3'(LOCK_FIELDS))
      else $error("quality without lock");
   a_std_sel: assert property (@(posedge clk_i) disable iff (reset_i)
      field_start && s_q.line_cnt < 10'(LINES_THRESHOLD) |=> s_q.std_525)
      else $error("standard not detected");
   a_sample_rate: assert property (@(posedge clk_i) disable iff (reset_i)
      sample_en |=> !sample_en)
      else $error("sample enable too fast");
   a_status_read: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_i && addr_i[3:0] == OFS_STATUS |=> rdata_o[BIT_QUALITY]
      == $past(s_q.quality))
      else $error("status read mismatch");
   c_capture: cover property (@(posedge clk_i) commit);
   c_irq: cover property (@(posedge clk_i) irq_o);
   c_lock: cover property (@(posedge clk_i) s_q.quality);
   c_line_end: cover property (@(posedge clk_i) line_end);
endmodule : caption_capture
`default_nettype wire

// file: core/caption_pkg.sv
// package: register map, fields and timing constants for caption capture
`default_nettype none
package caption_pkg;
   // register offsets
   localparam logic [3:0] OFS_INPUT_CTRL   = 4'h0;
   localparam logic [3:0] OFS_MODE_CTRL    = 4'h1;
   localparam logic [3:0] OFS_LINE_SELECT  = 4'h2;
   localparam logic [3:0] OFS_STATUS       = 4'h3;
   localparam logic [3:0] OFS_BYTE_FIRST   = 4'h4;
   localparam logic [3:0] OFS_BYTE_SECOND  = 4'h5;
   localparam logic [3:0] OFS_IRQ_STATUS   = 4'h6;
   localparam logic [3:0] OFS_IRQ_MASK     = 4'h7;
   // field positions
   localparam int BIT_INPUT_SEL    = 0;
   localparam int BIT_CAPTURE_EN   = 0;
   localparam int BIT_QUALITY      = 0;
   localparam int BIT_STD_525      = 1;
   localparam int BIT_IRQ_CAPTION  = 0;
   // reset values
   localparam logic [4:0] LINE_SELECT_RST = 5'h15;
   localparam logic [7:0] BYTE_RST        = 8'h00;
   // timing
   localparam int CLK_HZ           = 50_000_000;
   localparam int SAMPLE_HZ        = 12_000_000;
   localparam int BIT_RATE_HZ      = 503_500;
   localparam int SAMPLES_PER_BIT  =
      (SAMPLE_HZ + BIT_RATE_HZ / 2) / BIT_RATE_HZ;
   localparam int LINES_525        = 525;
   localparam int LINES_625        = 625;
   localparam int LINES_THRESHOLD  = (LINES_525 + LINES_625) / 4;
   localparam int LOCK_FIELDS      = 4;
   localparam int START_BITS       = 3;
   localparam int DATA_BITS        = 16;
   localparam logic [7:0] SLICE_LEVEL = 8'h80;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic hsync;
      logic vsync;
   } sync_s;
endpackage : caption_pkg
`default_nettype wire

// file: core/caption_shift.sv
// serial-to-parallel store for the two caption bytes of a line
`default_nettype none
module caption_shift
   import caption_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // control
   input  wire logic       clear_i,
   input  wire logic       bit_valid_i,
   input  wire logic       bit_i,
   input  wire logic       commit_i,
   // stored bytes
   output logic [7:0]      byte_first_o,
   output logic [7:0]      byte_second_o
);
   typedef struct packed {
      logic [15:0] sreg;
      logic [7:0]  b1;
      logic [7:0]  b2;
   } shift_state_s;

   shift_state_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (clear_i) begin
         s_d.b1   = BYTE_RST;
         s_d.b2   = BYTE_RST;
         s_d.sreg = 16'h0000;
      end else if (bit_valid_i) begin
         s_d.sreg = {bit_i, s_q.sreg[15:1]};
      end else if (commit_i) begin
         s_d.b1 = s_q.sreg[7:0];
         s_d.b2 = s_q.sreg[15:8];
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign byte_first_o  = s_q.b1;
   assign byte_second_o = s_q.b2;
endmodule : caption_shift
`default_nettype wire

// file: verification/caption_capture_bench.sv
// bench: caption capture driven by two video source models
`default_nettype none
module caption_capture_bench
   import caption_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] QUAL = 8'(1 << BIT_QUALITY);
   localparam logic [7:0] S525 = 8'(1 << BIT_STD_525);
   localparam logic [7:0] IRQB = 8'(1 << BIT_IRQ_CAPTION);
   logic       clk_i   = 1'b0;
   logic       reset_i = 1'b1;
   logic [7:0] addr_i  = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i    = 1'b0;
   logic       rd_i    = 1'b0;
   logic [7:0] rdata_o;
   logic       irq_o;
   logic [7:0] video0, video1, e0a, e0b, e1a, e1b, prev;
   logic       hsync0, vsync0, hsync1, vsync1;
   int         fail_count = 0;
   int         num_checks = 0;
   int         cap_line   = int'(LINE_SELECT_RST);

   caption_capture u_caption_capture (
      .clk_i(clk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o),
      .video0_i(video0), .video1_i(video1),
      .hsync0_i(hsync0), .vsync0_i(vsync0),
      .hsync1_i(hsync1), .vsync1_i(vsync1),
      .irq_o(irq_o)
   );
   video_source u_video_source_0 (
      .clk_i(clk_i), .video_o(video0), .hsync_o(hsync0), .vsync_o(vsync0)
   );
   video_source u_video_source_1 (
      .clk_i(clk_i), .video_o(video1), .hsync_o(hsync1), .vsync_o(vsync1)
   );

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= {4'h0, a};
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_i);
      addr_i <= {4'h0, a};
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 chk(nm, e, rdata_o);
   endtask : rd

   // n fields on both inputs at once, fresh random bytes per field
   task automatic run(input int lines, input int n, input bit cap);
      repeat (n) begin
         e0a = 8'($urandom);
         e0b = 8'($urandom);
         e1a = 8'($urandom);
         e1b = 8'($urandom);
         fork
            u_video_source_0.field(lines, cap_line, cap, e0a, e0b);
            u_video_source_1.field(lines, cap_line, cap, e1a, e1b);
         join
      end
   endtask : run

   initial begin
      repeat (95000) @(posedge clk_i);
      fail_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'h99e5));
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(OFS_LINE_SELECT, {3'h0, LINE_SELECT_RST}, "line_sel");
      rd(OFS_BYTE_FIRST, BYTE_RST, "b1");
      rd(OFS_BYTE_SECOND, BYTE_RST, "b2");
      rd(4'h8, 8'h00, "unmapped");
      chk("irq", 8'h00, {7'h0, irq_o});
      wr(OFS_INPUT_CTRL, 8'h00);
      wr(OFS_MODE_CTRL, 8'(1 << BIT_CAPTURE_EN));
      wr(OFS_IRQ_MASK, IRQB);
      run(262, 6, 1'b1);
      rd(OFS_STATUS, QUAL | S525, "status");
      rd(OFS_BYTE_FIRST, e0a, "b1");
      rd(OFS_BYTE_SECOND, e0b, "b2");
      chk("irq", 8'h01, {7'h0, irq_o});
      wr(OFS_BYTE_FIRST, ~e0a);
      wr(OFS_BYTE_SECOND, ~e0b);
      rd(OFS_BYTE_FIRST, e0a, "b1_ro");
      rd(OFS_BYTE_SECOND, e0b, "b2_ro");
      wr(OFS_IRQ_STATUS, IRQB);
      rd(OFS_IRQ_STATUS, 8'h00, "irq_stat");
      chk("irq", 8'h00, {7'h0, irq_o});
      wr(OFS_INPUT_CTRL, 8'(1 << BIT_INPUT_SEL));
      run(262, 1, 1'b1);
      rd(OFS_BYTE_FIRST, e1a, "b1_in1");
      rd(OFS_BYTE_SECOND, e1b, "b2_in1");
      wr(OFS_IRQ_STATUS, IRQB);
      wr(OFS_IRQ_MASK, 8'h00);
      run(262, 1, 1'b1);
      rd(OFS_IRQ_STATUS, IRQB, "irq_stat");
      chk("irq_masked", 8'h00, {7'h0, irq_o});
      wr(OFS_IRQ_STATUS, IRQB);
      wr(OFS_IRQ_MASK, IRQB);
      cap_line = 18;
      wr(OFS_LINE_SELECT, 8'(cap_line));
      run(262, 1, 1'b1);
      rd(OFS_BYTE_FIRST, e1a, "b1_line");
      rd(OFS_BYTE_SECOND, e1b, "b2_line");
      prev = e1a;
      wr(OFS_MODE_CTRL, 8'h00);
      wr(OFS_IRQ_STATUS, IRQB);
      run(262, 1, 1'b1);
      rd(OFS_IRQ_STATUS, 8'h00, "irq_off");
      rd(OFS_BYTE_FIRST, prev, "b1_off");
      run(312, 6, 1'b0);
      rd(OFS_STATUS, QUAL, "status");
      end_of_test();
   end
endmodule : caption_capture_bench
`default_nettype wire

// file: verification/video_source.sv
// video source model: sync pulses, blank level, caption line waveform
`default_nettype none
module video_source
   import caption_pkg::*;
(
   // clock
   input  wire logic      clk_i,
   // digitised video with extracted sync
   output var logic [7:0] video_o,
   output var logic       hsync_o,
   output var logic       vsync_o
);
   localparam int BIT_CLKS = CLK_HZ / BIT_RATE_HZ;
   localparam logic [7:0] BLANK = 8'h10;
   localparam logic [7:0] PEAK  = 8'hc0;

   initial begin
      video_o = BLANK;
      hsync_o = 1'b0;
      vsync_o = 1'b0;
   end

   // one field; caption bytes on cap_line when cap is set
   task automatic field(input int lines, input int cap_line, input bit cap,
                        input logic [7:0] ba, input logic [7:0] bb);
      logic [18:0] sr;
      sr = {bb, ba, 3'b001};
      @(posedge clk_i);
      vsync_o <= 1'b1;
      for (int i = 1; i <= lines; i++) begin
         @(posedge clk_i);
         hsync_o <= 1'b1;
         if (i == 4) begin
            vsync_o <= 1'b0;
         end
         repeat (5) @(posedge clk_i);
         hsync_o <= 1'b0;
         if (cap && i == cap_line) begin
            repeat (60) @(posedge clk_i);
            for (int b = 0; b < 19; b++) begin
               video_o <= sr[b] ? PEAK : BLANK;
               repeat (BIT_CLKS) @(posedge clk_i);
            end
            video_o <= BLANK;
            repeat (100) @(posedge clk_i);
         end else begin
            repeat (6) @(posedge clk_i);
         end
      end
   endtask : field
endmodule : video_source
`default_nettype wire
